/* File: core/ccd_params.svh */
// register indices, field positions and reset values of the channel dividers
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define CCD_IX_D0_CNT   9'h190
`define CCD_IX_D0_PH    9'h191
`define CCD_IX_D0_CTL   9'h192
`define CCD_IX_D1_CNT   9'h196
`define CCD_IX_D1_PH    9'h197
`define CCD_IX_D1_CTL   9'h198
`define CCD_IX_D2_S1    9'h199
`define CCD_IX_D2_S2    9'h19b
`define CCD_IX_D2_BYP   9'h19c
`define CCD_IX_D2_DUTY  9'h19d
`define CCD_IX_D3_S1    9'h19e
`define CCD_IX_D3_S2    9'h1a0
`define CCD_IX_D3_BYP   9'h1a1
`define CCD_IX_D3_DUTY  9'h1a2
`define CCD_IX_OUT_EN   9'h1b0
`define CCD_IX_SYNC     9'h1b1
`define CCD_IX_STATUS   9'h1b2

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCD_M_HI        7
`define CCD_M_LO        4
`define CCD_N_HI        3
`define CCD_N_LO        0
`define CCD_PO_HI       3
`define CCD_PO_LO       0
`define CCD_SH_BIT      4
`define CCD_BYP_BIT     7
`define CCD_DIS_BIT     0
`define CCD_DIRECT_BIT  1
`define CCD_BYP1_BIT    4
`define CCD_BYP2_BIT    5
`define CCD_SYNC_BIT    0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCD_REG_RST     8'h00
`define CCD_OEN_RST     8'h00

`endif

/* File: core/ccd_pkg.sv */
// types shared by the channel divider files
package ccd_pkg;
	typedef logic [3:0] ccd_nib_t;
	typedef logic [4:0] ccd_cyc_t;
	typedef logic [7:0] ccd_reg_t;
	typedef enum logic [3:0] {
		ST_BYP  = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_HIGH = 4'b0100,
		ST_LOW  = 4'b1000
	} ccd_st_t;
	typedef struct packed {
		ccd_st_t  st;
		ccd_cyc_t cnt;
		logic     out;
		logic     in_q;
		logic     half;
	} ccd_stage_t;
	typedef struct packed {
		logic ready;
		logic err;
	} ccd_apb_t;
	typedef struct packed {
		ccd_reg_t [14:0] regs;
		logic [31:0]     rdata;
		logic            sync;
		logic [5:0]      outs;
	} ccd_top_t;
endpackage

/* File: core/ccd_apb_port.sv */
// apb handshake: one wait state, error on unmapped address
`timescale 1ns/1ps
`default_nettype none
module ccd_apb_port (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic psel,
	input  wire logic penable,
	input  wire logic hit,
	output logic      req,
	output logic      take,
	output logic      ready,
	output logic      err
);
	import ccd_pkg::*;
	ccd_apb_t q;
	ccd_apb_t d;

	// first access cycle asks for data, second one completes
	assign req = psel & penable & ~q.ready;
	assign take = psel & penable & q.ready;
	assign ready = q.ready;
	assign err = q.err;

	always_comb begin
		d.ready = req;
		d.err = req & ~hit;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	ready_once_a: assert property (q.ready |=> !q.ready)
		else $error("ready held longer than one cycle");
endmodule
`default_nettype wire

/* File: core/ccd_stage.sv */
// one divide stage: low/high counting, bypass, duty fix and start delay
`timescale 1ns/1ps
`default_nettype none
module ccd_stage (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              src_lvl,
	input  wire ccd_pkg::ccd_nib_t m,
	input  wire ccd_pkg::ccd_nib_t n,
	input  wire logic              byp,
	input  wire logic              fix_dis,
	input  wire ccd_pkg::ccd_cyc_t dly,
	input  wire logic              sync,
	output logic                   out
);
	import ccd_pkg::*;
	ccd_stage_t q;
	ccd_stage_t d;
	logic       rise;
	logic       fall;
	logic       odd_fix;

	assign rise = src_lvl & ~q.in_q;
	assign fall = ~src_lvl & q.in_q;
	assign odd_fix = ~fix_dis & ({1'b0, m} == {1'b0, n} + 5'h01);
	assign out = q.out;

	always_comb begin
		d = q;
		d.in_q = src_lvl;
		if (byp) begin
			// counter held idle, input passes with its own duty
			d.st = ST_BYP;
			d.out = src_lvl;
			d.cnt = 5'h00;
			d.half = 1'b0;
		end else if (sync) begin
			d.st = ST_WAIT;
			d.cnt = dly;
			d.out = 1'b0;
			d.half = 1'b0;
		end else begin
			unique case (q.st)
			ST_BYP: begin
				d.st = ST_WAIT;
				d.cnt = 5'h00;
				d.out = 1'b0;
			end
			ST_WAIT: if (rise) begin
				if (q.cnt == 5'h00) begin
					d.out = 1'b1;
					d.st = ST_HIGH;
					d.cnt = {1'b0, n};
				end else begin
					d.cnt = q.cnt - 5'h01;
				end
			end
			ST_HIGH: if (rise) begin
				if (q.cnt == 5'h00) begin
					d.st = ST_LOW;
					d.cnt = {1'b0, m};
					// odd ratio with M one above N and fix enabled: stay high another half cycle
					if (odd_fix) begin
						d.half = 1'b1;
					end else begin
						d.out = 1'b0;
					end
				end else begin
					d.cnt = q.cnt - 5'h01;
				end
			end
			ST_LOW: if (q.half && fall) begin
				d.out = 1'b0;
				d.half = 1'b0;
			end else if (rise) begin
				if (q.cnt == 5'h00) begin
					d.out = 1'b1;
					d.st = ST_HIGH;
					d.cnt = {1'b0, n};
				end else begin
					d.cnt = q.cnt - 5'h01;
				end
			end
			default: begin
				d.st = ST_WAIT;
				d.cnt = 5'h00;
				d.out = 1'b0;
				d.half = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{st: ST_WAIT, cnt: 5'h00, out: 1'b0, in_q: 1'b0, half: 1'b0};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// checks: input edges counted per output phase
	// ----------------------------------------
	logic [5:0] rcnt;
	ccd_cyc_t   dly_h;
	ccd_nib_t   n_h;
	ccd_nib_t   m_h;
	always_ff @(posedge clk) begin
		// the bypass exit cycle ignores input edges, so it must not count them either
		if (rst || byp || sync || q.st == ST_BYP || d.out != q.out) begin
			rcnt <= 6'h00;
		end else begin
			rcnt <= rcnt + {5'h00, rise};
		end
		if (rst || byp) begin
			dly_h <= 5'h00;
		end else if (sync) begin
			dly_h <= dly;
		end
		// counts latched as each phase starts: a register write mid-phase must not skew the check
		if (d.st == ST_HIGH && q.st != ST_HIGH) begin
			n_h <= n;
		end
		if (d.st == ST_LOW && q.st != ST_LOW) begin
			m_h <= m;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence odd_end_s;
		q.st == ST_HIGH && rise && q.cnt == 5'h00 && odd_fix && !byp && !sync;
	endsequence
	sequence even_end_s;
		q.st == ST_HIGH && rise && q.cnt == 5'h00 && !odd_fix && !byp && !sync;
	endsequence
	byp_pass_a: assert property (byp && $past(byp) |-> q.out == $past(src_lvl))
		else $error("bypass output does not follow input");
	high_len_a: assert property (q.st != ST_BYP && q.out && !d.out && !byp && !sync
		|-> rcnt + {5'h00, rise} == {2'b00, n_h} + 6'h01)
		else $error("high phase length wrong");
	low_len_a: assert property (q.st == ST_LOW && d.st == ST_HIGH && !byp && !sync
		|-> rcnt + 6'h01 == {2'b00, m_h} + 6'h01)
		else $error("low phase length wrong");
	start_dly_a: assert property (q.st == ST_WAIT && d.st == ST_HIGH && !byp && !sync
		|-> rcnt + 6'h01 == {1'b0, dly_h} + 6'h01)
		else $error("start delay wrong");
	sync_start_a: assert property (sync && !byp
		|=> q.st == ST_WAIT && !q.out && q.cnt == $past(dly))
		else $error("sync did not restart divider");
	even_fall_a: assert property (even_end_s
		|=> !q.out && q.st == ST_LOW && q.cnt == {1'b0, $past(m)})
		else $error("output did not fall on rising input");
	half_hold_a: assert property (odd_end_s |=> q.out && q.half)
		else $error("odd ratio did not hold half cycle");
	half_fall_a: assert property (q.st == ST_LOW && q.half && fall && !byp && !sync
		|=> !q.out && !q.half)
		else $error("half cycle fall missed");
endmodule
`default_nettype wire

/* File: core/ccd_top.sv */
// channel clock dividers with duty fix and coarse phase, apb registers
//
// Function
// - duty fix on after reset; per-divider disable bit turns it off
// - uncorrected output high N+1 of N+M+2 input cycles
// - passed-through input keeps its own duty cycle
// - single-stage output rise delayed by whole input cycles
// - delay code: start-high weight 16, offset bits 8,4,2,1
// - with start-high set delay is offset plus M plus one
// - phase offset only applies after sync; software must sync
// - count register: low count bits 7:4, high count bits 3:0
// - cascaded channel is two 2-to-32 stages, product ratio
// - each count field holds cycles minus one
// - cascade ratio: 1, stage one alone, or product
// - one disable bit per cascade; bypass bits 4 and 5
// - B outputs off after reset until software enables
// - single stage divides by N+M+2, from 2 to 32
// - bypass bit passes input, ratio one, counter idle
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_params.svh"
module ccd_top (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        SRC_CLK,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             OUT_D0,
	output logic             OUT_D1,
	output logic             OUT_D2A,
	output logic             OUT_D2B,
	output logic             OUT_D3A,
	output logic             OUT_D3B
);
	import ccd_pkg::*;

	// ----------------------------------------
	// register slots
	// ----------------------------------------
	localparam logic [4:0] SL_D0_CNT  = 5'h00;
	localparam logic [4:0] SL_D0_PH   = 5'h01;
	localparam logic [4:0] SL_D0_CTL  = 5'h02;
	localparam logic [4:0] SL_D1_CNT  = 5'h03;
	localparam logic [4:0] SL_D1_PH   = 5'h04;
	localparam logic [4:0] SL_D1_CTL  = 5'h05;
	localparam logic [4:0] SL_D2_S1   = 5'h06;
	localparam logic [4:0] SL_D2_S2   = 5'h07;
	localparam logic [4:0] SL_D2_BYP  = 5'h08;
	localparam logic [4:0] SL_D2_DUTY = 5'h09;
	localparam logic [4:0] SL_D3_S1   = 5'h0a;
	localparam logic [4:0] SL_D3_S2   = 5'h0b;
	localparam logic [4:0] SL_D3_BYP  = 5'h0c;
	localparam logic [4:0] SL_D3_DUTY = 5'h0d;
	localparam logic [4:0] SL_OUT_EN  = 5'h0e;
	localparam logic [4:0] SL_SYNC    = 5'h0f;
	localparam logic [4:0] SL_STATUS  = 5'h10;
	localparam logic [4:0] SL_NONE    = 5'h1f;

	localparam ccd_top_t TOP_RST = '{
		regs:  {`CCD_OEN_RST, {14{`CCD_REG_RST}}},
		rdata: 32'h0000_0000,
		sync:  1'b0,
		outs:  6'h00
	};

	// ----------------------------------------
	// state and wiring
	// ----------------------------------------
	ccd_top_t      q;
	ccd_top_t      d;
	logic [4:0]    sl;
	logic          hit;
	logic          ap_req;
	logic          ap_take;
	logic          ap_ready;
	logic          ap_err;
	wire  [5:0]    st_in;
	wire  [5:0]    st_byp;
	wire  [5:0]    st_dis;
	wire  [5:0]    st_out;
	wire ccd_nib_t cfg_m   [6];
	wire ccd_nib_t cfg_n   [6];
	wire ccd_cyc_t cfg_dly [6];

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [4:0] slot_of(input logic [11:0] a);
		logic [8:0] ix;
		ix = a[10:2];
		slot_of = SL_NONE;
		if (a[11] == 1'b0 && a[1:0] == 2'b00) begin
			case (ix)
			`CCD_IX_D0_CNT:  slot_of = SL_D0_CNT;
			`CCD_IX_D0_PH:   slot_of = SL_D0_PH;
			`CCD_IX_D0_CTL:  slot_of = SL_D0_CTL;
			`CCD_IX_D1_CNT:  slot_of = SL_D1_CNT;
			`CCD_IX_D1_PH:   slot_of = SL_D1_PH;
			`CCD_IX_D1_CTL:  slot_of = SL_D1_CTL;
			`CCD_IX_D2_S1:   slot_of = SL_D2_S1;
			`CCD_IX_D2_S2:   slot_of = SL_D2_S2;
			`CCD_IX_D2_BYP:  slot_of = SL_D2_BYP;
			`CCD_IX_D2_DUTY: slot_of = SL_D2_DUTY;
			`CCD_IX_D3_S1:   slot_of = SL_D3_S1;
			`CCD_IX_D3_S2:   slot_of = SL_D3_S2;
			`CCD_IX_D3_BYP:  slot_of = SL_D3_BYP;
			`CCD_IX_D3_DUTY: slot_of = SL_D3_DUTY;
			`CCD_IX_OUT_EN:  slot_of = SL_OUT_EN;
			`CCD_IX_SYNC:    slot_of = SL_SYNC;
			`CCD_IX_STATUS:  slot_of = SL_STATUS;
			default:         slot_of = SL_NONE;
			endcase
		end
	endfunction

	assign hit = slot_of(PADDR) != SL_NONE;

	ccd_apb_port u_apb (
		.clk     (CLK),
		.rst     (RST),
		.psel    (PSEL),
		.penable (PENABLE),
		.hit     (hit),
		.req     (ap_req),
		.take    (ap_take),
		.ready   (ap_ready),
		.err     (ap_err)
	);

	// ----------------------------------------
	// single-stage dividers 0 and 1
	// ----------------------------------------
	genvar gc;
	for (gc = 0; gc < 2; gc++) begin : g_single
		localparam int CS = 3 * gc;
		logic [7:0] cnt_r;
		logic [7:0] ph_r;
		logic [7:0] ctl_r;
		assign cnt_r = q.regs[CS];
		assign ph_r = q.regs[CS + 1];
		assign ctl_r = q.regs[CS + 2];
		assign st_in[gc] = SRC_CLK;
		assign cfg_m[gc] = cnt_r[`CCD_M_HI:`CCD_M_LO];
		assign cfg_n[gc] = cnt_r[`CCD_N_HI:`CCD_N_LO];
		assign st_byp[gc] = ph_r[`CCD_BYP_BIT];
		assign st_dis[gc] = ctl_r[`CCD_DIS_BIT];
		// start-high adds the low phase on top of the offset
		assign cfg_dly[gc] = ph_r[`CCD_SH_BIT]
			? {1'b0, ph_r[`CCD_PO_HI:`CCD_PO_LO]} + {1'b0, cfg_m[gc]} + 5'h01
			: {1'b0, ph_r[`CCD_PO_HI:`CCD_PO_LO]};
	end

	// ----------------------------------------
	// cascaded dividers 2 and 3
	// ----------------------------------------
	for (gc = 0; gc < 2; gc++) begin : g_cascade
		localparam int CS = 6 + 4 * gc;
		localparam int S1 = 2 + 2 * gc;
		logic [7:0] s1_r;
		logic [7:0] s2_r;
		logic [7:0] byp_r;
		logic [7:0] duty_r;
		assign s1_r = q.regs[CS];
		assign s2_r = q.regs[CS + 1];
		assign byp_r = q.regs[CS + 2];
		assign duty_r = q.regs[CS + 3];
		// stage two counts the output of stage one
		assign st_in[S1] = SRC_CLK;
		assign st_in[S1 + 1] = st_out[S1];
		assign cfg_m[S1] = s1_r[`CCD_M_HI:`CCD_M_LO];
		assign cfg_n[S1] = s1_r[`CCD_N_HI:`CCD_N_LO];
		assign cfg_m[S1 + 1] = s2_r[`CCD_M_HI:`CCD_M_LO];
		assign cfg_n[S1 + 1] = s2_r[`CCD_N_HI:`CCD_N_LO];
		assign st_byp[S1] = byp_r[`CCD_BYP1_BIT];
		assign st_byp[S1 + 1] = byp_r[`CCD_BYP2_BIT];
		assign st_dis[S1] = duty_r[`CCD_DIS_BIT];
		assign st_dis[S1 + 1] = duty_r[`CCD_DIS_BIT];
		// cascade offsets are not supported, both stages start at once
		assign cfg_dly[S1] = 5'h00;
		assign cfg_dly[S1 + 1] = 5'h00;
	end

	// ----------------------------------------
	// divide stages
	// ----------------------------------------
	genvar gi;
	for (gi = 0; gi < 6; gi++) begin : g_stage
		ccd_stage u_stage (
			.clk     (CLK),
			.rst     (RST),
			.src_lvl (st_in[gi]),
			.m       (cfg_m[gi]),
			.n       (cfg_n[gi]),
			.byp     (st_byp[gi]),
			.fix_dis (st_dis[gi]),
			.dly     (cfg_dly[gi]),
			.sync    (q.sync),
			.out     (st_out[gi])
		);
	end

	// ----------------------------------------
	// register file and output stage
	// ----------------------------------------
	always_comb begin
		d = q;
		sl = slot_of(PADDR);
		d.sync = 1'b0;
		if (ap_req) begin
			d.rdata = 32'h0000_0000;
			if (sl <= SL_OUT_EN) begin
				d.rdata = {24'h00_0000, q.regs[sl[3:0]]};
			end else if (sl == SL_STATUS) begin
				d.rdata = {26'h000_0000, st_out};
			end
		end
		if (ap_take && PWRITE && !ap_err) begin
			if (sl <= SL_OUT_EN) begin
				d.regs[sl[3:0]] = PWDATA[7:0];
			end else if (sl == SL_SYNC) begin
				// one-cycle restart of every divider
				d.sync = PWDATA[`CCD_SYNC_BIT];
			end
		end
		// direct route hands the source level straight to the output of divider 0 or 1
		d.outs[0] = q.regs[SL_D0_CTL][`CCD_DIRECT_BIT] ? SRC_CLK : st_out[0];
		d.outs[1] = q.regs[SL_D1_CTL][`CCD_DIRECT_BIT] ? SRC_CLK : st_out[1];
		d.outs[2] = st_out[3];
		d.outs[3] = st_out[3] & q.regs[SL_OUT_EN][0];
		d.outs[4] = st_out[5];
		d.outs[5] = st_out[5] & q.regs[SL_OUT_EN][1];
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	assign PRDATA = q.rdata;
	assign PREADY = ap_ready;
	assign PSLVERR = ap_err;
	assign OUT_D0 = q.outs[0];
	assign OUT_D1 = q.outs[1];
	assign OUT_D2A = q.outs[2];
	assign OUT_D2B = q.outs[3];
	assign OUT_D3A = q.outs[4];
	assign OUT_D3B = q.outs[5];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	apb_ready_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("apb answer not in one wait state");
	reset_state_a: assert property (disable iff (1'b0) RST |=>
		!q.regs[SL_D0_CTL][0] && !q.regs[SL_D1_CTL][0] && !q.regs[SL_D2_DUTY][0]
		&& !q.regs[SL_D3_DUTY][0] && !OUT_D2B && !OUT_D3B)
		else $error("reset state wrong");
	casc_byp_a: assert property (st_byp[3] && $past(st_byp[3])
		|-> st_out[3] == $past(st_out[2]))
		else $error("bypassed second stage does not pass first stage");
endmodule
`default_nettype wire

/* File: testbench/ccd_clk_sink.sv */
// downstream clock receiver that times the high and low phases of one divided clock
`timescale 1ns/1ps
`default_nettype none
module ccd_clk_sink (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   clr,
	input  wire logic   sig,
	output logic [15:0] hi_len,
	output logic [15:0] lo_len,
	output logic [7:0]  n_rise,
	output logic [31:0] first_t
);
	logic        prev;
	logic [15:0] run;
	logic [31:0] now;
	// lengths are latched at the edge that ends a phase, so a level seen for L cycles reads L
	always @(posedge clk) begin
		now <= rst ? 32'h0 : now + 32'h1;
		prev <= sig;
		run <= (sig != prev) ? 16'h1 : run + 16'h1;
		if (rst || clr) begin
			n_rise <= 8'h0;
			first_t <= 32'h0;
		end else if (sig && !prev) begin
			lo_len <= run;
			n_rise <= n_rise + 8'h1;
			if (n_rise == 8'h0)
				first_t <= now;
		end else if (!sig && prev)
			hi_len <= run;
	end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench: apb map, divider ratios, duty fix, pass-through, phase, cascade
`timescale 1ns/1ps
`default_nettype none
`include "ccd_params.svh"
module tb_top;
	import ccd_pkg::*;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic        SRC_CLK = 1'b0;
	logic        PSEL = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	wire  [5:0]  outs;
	logic [5:0]  clr = 6'h00;
	logic [15:0] hi_len [6];
	logic [15:0] lo_len [6];
	logic [7:0]  n_rise [6];
	logic [31:0] first_t [6];
	logic [31:0] seed = 32'hecf0;
	logic [31:0] rd;
	logic        err;
	logic [8:0]  ixs [15] = '{`CCD_IX_D0_CNT, `CCD_IX_D0_PH, `CCD_IX_D0_CTL, `CCD_IX_D1_CNT,
		`CCD_IX_D1_PH, `CCD_IX_D1_CTL, `CCD_IX_D2_S1, `CCD_IX_D2_S2, `CCD_IX_D2_BYP,
		`CCD_IX_D2_DUTY, `CCD_IX_D3_S1, `CCD_IX_D3_S2, `CCD_IX_D3_BYP, `CCD_IX_D3_DUTY,
		`CCD_IX_OUT_EN};
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          src_hi = 2;
	int          src_lo = 2;
	int          src_n = 0;

	always #2.5 CLK = ~CLK;
	// source level only changes on CLK edges so every phase length is a whole cycle count
	always @(posedge CLK) begin
		src_n <= src_n + 1;
		if (src_n + 1 >= (SRC_CLK ? src_hi : src_lo)) begin
			SRC_CLK <= ~SRC_CLK;
			src_n <= 0;
		end
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			error_cnt++;
			test_done();
		end
	end

	ccd_top dut (
		.CLK     (CLK),
		.RST     (RST),
		.SRC_CLK (SRC_CLK),
		.PSEL    (PSEL),
		.PENABLE (PENABLE),
		.PWRITE  (PWRITE),
		.PADDR   (PADDR),
		.PWDATA  (PWDATA),
		.PRDATA  (PRDATA),
		.PREADY  (PREADY),
		.PSLVERR (PSLVERR),
		.OUT_D0  (outs[0]),
		.OUT_D1  (outs[1]),
		.OUT_D2A (outs[2]),
		.OUT_D2B (outs[3]),
		.OUT_D3A (outs[4]),
		.OUT_D3B (outs[5])
	);
	genvar gi;
	for (gi = 0; gi < 6; gi = gi + 1) begin : g_sink
		ccd_clk_sink u_sink (
			.clk     (CLK),
			.rst     (RST),
			.clr     (clr[gi]),
			.sig     (outs[gi]),
			.hi_len  (hi_len[gi]),
			.lo_len  (lo_len[gi]),
			.n_rise  (n_rise[gi]),
			.first_t (first_t[gi])
		);
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int sp();
		return src_hi + src_lo;
	endfunction
	// odd corrected ratios hold high until the next source fall
	function automatic int exp_hi(logic [3:0] n, logic [3:0] m, logic fix);
		return (n + 1) * sp() + ((fix && {1'b0, m} == n + 5'h01) ? src_hi : 0);
	endfunction
	function automatic int exp_dly(logic [4:0] c, logic [3:0] m);
		return (c[4] ? c[3:0] + m + 1 : c) * sp();
	endfunction

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= {1'b0, idx, 2'b00};
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		// this wait ends on PREADY; if PREADY never rises, only the bench timeout ends it
		while (PREADY !== 1'b1) begin
			@(posedge CLK);
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [8:0] idx, input logic [7:0] v);
		apb(1'b1, idx, {24'h0, v});
	endtask
	task automatic meas(input int ch, output logic [15:0] h, output logic [15:0] l);
		int k;
		k = 0;
		clr[ch] <= 1'b1;
		repeat (2) @(posedge CLK);
		clr[ch] <= 1'b0;
		while (n_rise[ch] < 3 && k < 4000) begin
			@(posedge CLK);
			k++;
		end
		h = hi_len[ch];
		l = lo_len[ch];
	endtask
	// rise of divider 0 after divider 1, folded into one period
	task automatic skew(input int per, output int s);
		int k;
		k = 0;
		clr[1:0] <= 2'b11;
		repeat (2) @(posedge CLK);
		clr[1:0] <= 2'b00;
		while ((n_rise[0] < 1 || n_rise[1] < 1) && k < 2000) begin
			@(posedge CLK);
			k++;
		end
		s = (int'(first_t[0]) - int'(first_t[1]) + per) % per;
	endtask

	initial begin
		logic [15:0] h;
		logic [15:0] l;
		logic [7:0]  r;
		logic [3:0]  n;
		logic [3:0]  m;
		logic [3:0]  n2;
		logic [3:0]  m2;
		logic [4:0]  codes [5];
		logic        dis;
		int          d;
		int          s;
		int          per;
		int          hx;
		int          t;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		foreach (ixs[i]) begin
			apb(1'b0, ixs[i], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		chk("b outputs idle", 32'h0, {24'h0, n_rise[3] | n_rise[5]});
		wr(`CCD_IX_OUT_EN, 8'h03);
		for (t = 3; t < 6; t += 2) begin
			meas(t, h, l);
			chk("b output high", 2 * sp(), {16'h0, h});
			chk("b output low", 2 * sp(), {16'h0, l});
		end
		apb(1'b1, 9'h1ff, 32'h5a);
		chk("unmapped write error", 32'h1, {31'h0, err});
		apb(1'b0, 9'h1ff, 32'h0);
		chk("unmapped read error", 32'h1, {31'h0, err});
		chk("unmapped read data", 32'h0, rd);
		apb(1'b1, `CCD_IX_STATUS, 32'h3f);
		chk("status write error", 32'h0, {31'h0, err});
		apb(1'b0, `CCD_IX_SYNC, 32'h0);
		chk("sync read data", 32'h0, rd);
		foreach (ixs[i]) begin
			r = 8'(xs());
			// stage one is never bypassed alone while stage two runs
			if (ixs[i] == `CCD_IX_D2_BYP || ixs[i] == `CCD_IX_D3_BYP) begin
				r = r | {2'b00, r[4], 5'h00};
			end
			wr(ixs[i], r);
			apb(1'b0, ixs[i], 32'h0);
			chk("read back", {24'h0, r}, rd);
			wr(ixs[i], 8'h00);
		end
		$display("test registers done");
		for (t = 0; t < 8; t++) begin
			n = 4'(xs());
			m = 4'(xs());
			case (t / 2)
				1: m = n;
				2: begin
					n = (n == 4'hf) ? 4'he : n;
					m = n + 4'h1;
				end
				3: begin
					n = 4'hf;
					m = t[0] ? 4'h0 : 4'hf;
				end
				default: ;
			endcase
			dis = (t / 2 == 0 || t / 2 == 3);
			d = t % 2;
			wr(d ? `CCD_IX_D1_CNT : `CCD_IX_D0_CNT, {m, n});
			wr(d ? `CCD_IX_D1_CTL : `CCD_IX_D0_CTL, {7'h0, dis});
			wr(`CCD_IX_SYNC, 8'h01);
			meas(d, h, l);
			chk("divider high", exp_hi(n, m, !dis), {16'h0, h});
			chk("divider low", (n + m + 2) * sp() - exp_hi(n, m, !dis), {16'h0, l});
		end
		$display("test single stage done");
		src_hi = 3;
		src_lo = 2;
		// one divider bypassed and the other routed direct, then the roles swap
		for (d = 0; d < 2; d++) begin
			wr(d ? `CCD_IX_D1_PH : `CCD_IX_D0_PH, 8'h80);
			wr(d ? `CCD_IX_D0_CTL : `CCD_IX_D1_CTL, 8'h02);
			wr(`CCD_IX_D2_BYP, 8'h30);
			for (t = 0; t < 3; t++) begin
				meas(t, h, l);
				chk("pass high", 32'd3, {16'h0, h});
				chk("pass low", 32'd2, {16'h0, l});
			end
			wr(d ? `CCD_IX_D1_PH : `CCD_IX_D0_PH, 8'h00);
			wr(d ? `CCD_IX_D0_CTL : `CCD_IX_D1_CTL, 8'h00);
			wr(`CCD_IX_D2_BYP, 8'h00);
		end
		src_hi = 2;
		src_lo = 2;
		$display("test pass through done");
		// high count 15 keeps every delay below one period
		m = 4'(xs());
		wr(`CCD_IX_D0_CNT, {m, 4'hf});
		wr(`CCD_IX_D1_CNT, {m, 4'hf});
		per = (m + 17) * sp();
		codes = '{5'd0, 5'd15, 5'd16, 5'd31, 5'(xs())};
		wr(`CCD_IX_SYNC, 8'h01);
		d = 0;
		for (t = 0; t < 5; t++) begin
			wr(`CCD_IX_D0_PH, {3'h0, codes[t]});
			skew(per, s);
			chk("skew before sync", d, s);
			wr(`CCD_IX_SYNC, 8'h01);
			skew(per, s);
			d = exp_dly(codes[t], m);
			chk("skew after sync", d, s);
		end
		$display("test phase done");
		for (t = 0; t < 4; t++) begin
			n = 4'(xs() % 4);
			m = 4'(xs() % 4);
			n2 = 4'(xs() % 4);
			m2 = 4'(xs() % 4);
			d = t % 2;
			wr(d ? `CCD_IX_D3_S1 : `CCD_IX_D2_S1, {m, n});
			wr(d ? `CCD_IX_D3_S2 : `CCD_IX_D2_S2, {m2, n2});
			wr(d ? `CCD_IX_D3_BYP : `CCD_IX_D2_BYP, (t < 2) ? 8'h00 : 8'h20);
			wr(d ? `CCD_IX_D3_DUTY : `CCD_IX_D2_DUTY, 8'h01);
			wr(`CCD_IX_SYNC, 8'h01);
			meas(d ? 4 : 2, h, l);
			per = (n + m + 2) * ((t < 2) ? (n2 + m2 + 2) : 1) * sp();
			hx = (t < 2) ? (n2 + 1) * (n + m + 2) * sp() : (n + 1) * sp();
			chk("cascade high", hx, {16'h0, h});
			chk("cascade low", per - hx, {16'h0, l});
		end
		$display("test cascade done");
		test_done();
	end
endmodule
`default_nettype wire
